// >>> design/cmp_pwm_pkg.sv
// cmp_pwm_pkg: shared constants for the compare/pwm unit and its helpers
// assumes: synthesizable sv, included before any design module
package cmp_pwm_pkg;
	// ==========================================================
	// widths
	localparam int TB_W      = 8;   // pwm timebase width
	localparam int DUTY_W    = 10;  // pwm duty width (ten bits)
	localparam int CMP_W     = 16;  // compare timebase / value width
	localparam int MODE_W    = 5;   // timebase mode field
	localparam int UMODE_W   = 4;   // unit mode field

	// ==========================================================
	// timebase mode field codes
	localparam logic [MODE_W-1:0] TB_MODE_FREE      = 5'h00;
	localparam logic [MODE_W-1:0] TB_MODE_LVL_LOW   = 5'h0e; // 01110
	localparam logic [MODE_W-1:0] TB_MODE_LVL_HIGH  = 5'h0f; // 01111

	// ==========================================================
	// unit mode field codes
	localparam logic [UMODE_W-1:0] UM_OFF        = 4'h0;
	localparam logic [UMODE_W-1:0] UM_CMP_SET    = 4'h8;
	localparam logic [UMODE_W-1:0] UM_CMP_CLR    = 4'h9;
	localparam logic [UMODE_W-1:0] UM_CMP_TOGGLE = 4'h2;
	localparam logic [UMODE_W-1:0] UM_CMP_TRIG   = 4'hb;
	localparam logic [UMODE_W-1:0] UM_PWM        = 4'hf;

	// ==========================================================
	// prescale: instruction clock is mclk divided by four
	localparam int                 ICLK_DIV  = 4;
	localparam logic [1:0]         ICLK_LAST = 2'(ICLK_DIV - 1);

	// reset values
	localparam logic [TB_W-1:0]    TB_RST    = 8'h00;
	localparam logic [CMP_W-1:0]   CMP_RST   = 16'h0000;
endpackage

// >>> design/edge_sync.sv
// edge_sync: two-flop synchroniser with edge outputs for the trigger pin and the external compare clock
// assumes: single clock mclk, async active-low reset
`timescale 1ns/1ps
module edge_sync
	import cmp_pwm_pkg::*;
(
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic async_in,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	logic meta_r;
	logic sync_r;
	logic last_r;

	// ==========================================================
	// synchroniser: meta_r feeds only sync_r
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			last_r <= 1'b0;
		end else begin
			meta_r <= async_in;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end

	assign level = sync_r;
	assign rise  = sync_r & ~last_r;
	assign fall  = ~sync_r & last_r;
endmodule

// >>> design/iclk_div.sv
// iclk_div: instruction clock tick, one mclk pulse in every four
// assumes: single clock mclk, async active-low reset
`timescale 1ns/1ps
module iclk_div
	import cmp_pwm_pkg::*;
(
	input  wire logic mclk,
	input  wire logic rst_n,
	output logic      tick
);
	logic [1:0] cnt_r;

	// ==========================================================
	// free-running divider
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 2'h0;
		end else begin
			cnt_r <= cnt_r + 2'h1;
		end
	end

	assign tick = (cnt_r == ICLK_LAST);
endmodule

// >>> design/compare_pwm_one_shot.sv
// compare_pwm_one_shot: compare/pwm unit with one-shot pwm timebase
// assumes: config bits are plain ports from logic on mclk; trig_pin and
// cmp_ext_clk are asynchronous pins and are synchronised here
`timescale 1ns/1ps
module compare_pwm_one_shot
	import cmp_pwm_pkg::*;
(
	input  wire logic               mclk,
	input  wire logic               rst_n,
	// pwm timebase control
	input  wire logic               tb_enable_set,
	input  wire logic               tb_enable_clr,
	input  wire logic [MODE_W-1:0]  tb_mode,
	input  wire logic [TB_W-1:0]    pwm_timebase_period,
	output logic                    tb_enable,
	output logic [TB_W-1:0]         tb_count,
	// external reset/start signal (pin)
	input  wire logic               trig_pin,
	// unit control
	input  wire logic [UMODE_W-1:0] unit_control_register,
	input  wire logic               unit_control_write,
	input  wire logic [DUTY_W-1:0]  pwm_duty,
	// compare
	input  wire logic [7:0]         compare_value_high,
	input  wire logic [7:0]         compare_value_low,
	input  wire logic               cmp_clk_ext_sel,
	input  wire logic               cmp_ext_clk,
	input  wire logic               cmp_tb_run,
	input  wire logic               sleep_mode,
	input  wire logic               conv_src_sel,
	output logic [CMP_W-1:0]        cmp_count,
	// flags and outputs
	input  wire logic               flag_clear,
	output logic                    unit_interrupt_flag,
	output logic                    conv_trigger,
	output logic                    wake_request,
	output logic                    compare_pwm_pin,
	output logic                    unit_out_internal
);
	// ==========================================================
	// helpers
	logic iclk_tick;
	logic trig_level;
	logic trig_rise;
	logic trig_fall;
	logic ext_level;
	logic ext_rise;
	logic ext_fall;

	iclk_div u_div (
		.mclk (mclk),
		.rst_n(rst_n),
		.tick (iclk_tick)
	);

	edge_sync u_trig (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.async_in(trig_pin),
		.level   (trig_level),
		.rise    (trig_rise),
		.fall    (trig_fall)
	);

	// external compare clock sampled synchronously, never async counting
	edge_sync u_ext (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.async_in(cmp_ext_clk),
		.level   (ext_level),
		.rise    (ext_rise),
		.fall    (ext_fall)
	);

	// ==========================================================
	// mode decode
	function automatic logic is_cmp_mode(input logic [UMODE_W-1:0] m);
		return (m == UM_CMP_SET) || (m == UM_CMP_CLR)
			|| (m == UM_CMP_TOGGLE) || (m == UM_CMP_TRIG);
	endfunction

	logic one_shot;
	logic reset_lvl_high;
	logic at_reset_level;
	logic start_edge;
	logic pwm_mode;

	assign one_shot       = (tb_mode == TB_MODE_LVL_LOW) || (tb_mode == TB_MODE_LVL_HIGH);
	assign reset_lvl_high = (tb_mode == TB_MODE_LVL_HIGH);
	assign at_reset_level = (trig_level == reset_lvl_high);
	// edge away from the reset level into the active level
	assign start_edge     = reset_lvl_high ? trig_fall : trig_rise;
	assign pwm_mode       = (unit_control_register == UM_PWM);

	// ==========================================================
	// pwm timebase state
	typedef enum logic [1:0] {
		TB_IDLE,
		TB_ARMED,
		TB_RUN
	} tb_state_e;

	tb_state_e       tb_state_r;
	logic            tb_enable_r;
	logic [TB_W-1:0] tb_count_r;
	logic [1:0]      pre_r;
	logic            period_match;
	logic            tb_step;

	// pwm timebase advances on the instruction clock
	assign tb_step      = iclk_tick;
	assign period_match = (tb_count_r == pwm_timebase_period);

	// enable bit: set by software, cleared by software or one-shot end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tb_enable_r <= 1'b0;
		end else if (tb_enable_set) begin
			tb_enable_r <= 1'b1;
		end else if (tb_enable_clr) begin
			tb_enable_r <= 1'b0;
		end else if (one_shot && tb_state_r == TB_RUN && tb_step && period_match) begin
			tb_enable_r <= 1'b0;
		end
	end

	// one-shot sequencing; free mode runs whenever enabled
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tb_state_r <= TB_IDLE;
		end else begin
			case (tb_state_r)
				TB_IDLE: begin
					if (tb_enable_r && !tb_enable_clr) begin
						tb_state_r <= one_shot ? TB_ARMED : TB_RUN;
					end
				end
				TB_ARMED: begin
					// a fresh start edge is needed after each enable
					if (!tb_enable_r || !one_shot) begin
						tb_state_r <= TB_IDLE;
					end else if (start_edge) begin
						tb_state_r <= TB_RUN;
					end
				end
				TB_RUN: begin
					if (!tb_enable_r) begin
						tb_state_r <= TB_IDLE;
					end else if (one_shot && tb_step && period_match) begin
						tb_state_r <= TB_IDLE;
					end else if (one_shot && at_reset_level) begin
						tb_state_r <= TB_ARMED;
					end
				end
				default: begin
					tb_state_r <= TB_IDLE;
				end
			endcase
		end
	end

	// pwm timebase count; duty sub-bits use the two prescale bits
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tb_count_r <= TB_RST;
			pre_r      <= 2'h0;
		end else if (tb_state_r != TB_RUN || !tb_enable_r
			|| (one_shot && at_reset_level)) begin
			tb_count_r <= TB_RST;
			pre_r      <= 2'h0;
		end else begin
			pre_r <= pre_r + 2'h1;
			if (tb_step) begin
				if (period_match) begin
					tb_count_r <= TB_RST;
				end else begin
					tb_count_r <= tb_count_r + 8'h01;
				end
			end
		end
	end

	assign tb_enable = tb_enable_r;
	assign tb_count  = tb_count_r;

	// ==========================================================
	// pwm output
	logic               pwm_r;
	logic [DUTY_W-1:0]  duty_latch_r;
	logic [DUTY_W-1:0]  fine_count;
	logic               tb_running;
	logic               pulse_start;

	// ten-bit position: timebase count over two prescale bits
	assign fine_count  = {tb_count_r, pre_r};
	assign tb_running  = (tb_state_r == TB_RUN);
	// one-shot starts on the edge; free mode on each period wrap
	assign pulse_start = one_shot ? (tb_state_r == TB_ARMED && start_edge)
		: (tb_running && tb_step && period_match);

	// duty is latched at each period start so a nonzero write is glitch free
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			duty_latch_r <= '0;
		end else if (pulse_start || !tb_running) begin
			duty_latch_r <= pwm_duty;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pwm_r <= 1'b0;
		end else if (!pwm_mode || !tb_enable_r) begin
			pwm_r <= 1'b0;
		end else if (pwm_duty == '0) begin
			// zero duty cuts a running pulse short, no wait for the latch
			pwm_r <= 1'b0;
		end else if (pulse_start) begin
			pwm_r <= (pwm_duty != '0);
		end else if (tb_running && fine_count >= duty_latch_r) begin
			// duty at or above the period never reaches here: stays on
			pwm_r <= 1'b0;
		end else if (one_shot && tb_step && period_match) begin
			pwm_r <= 1'b0;
		end
	end

	// ==========================================================
	// compare timebase: iclk or synced external clock only
	logic [CMP_W-1:0] cmp_count_r;
	logic [CMP_W-1:0] cmp_value;
	logic             cmp_inc;
	logic             cmp_match;
	logic             cmp_match_d_r;
	logic             cmp_rst_pend_r;

	assign cmp_value = {compare_value_high, compare_value_low};
	assign cmp_inc   = cmp_tb_run && (cmp_clk_ext_sel ? ext_rise : iclk_tick);
	assign cmp_match = is_cmp_mode(unit_control_register) && (cmp_count_r == cmp_value);

	// reset in trigger mode happens one edge after the trigger edge,
	// and only if the match still holds then
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_count_r    <= CMP_RST;
			cmp_rst_pend_r <= 1'b0;
		end else begin
			cmp_rst_pend_r <= cmp_match && !cmp_match_d_r
				&& (unit_control_register == UM_CMP_TRIG);
			if (cmp_rst_pend_r && cmp_match) begin
				cmp_count_r <= CMP_RST;
			end else if (cmp_inc) begin
				cmp_count_r <= cmp_count_r + 16'h0001;
			end
		end
	end

	assign cmp_count = cmp_count_r;

	// ==========================================================
	// compare output latch
	logic cmp_out_r;
	logic cmp_event;

	assign cmp_event = cmp_match && !cmp_match_d_r;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_match_d_r <= 1'b0;
		end else begin
			cmp_match_d_r <= cmp_match;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_out_r <= 1'b0;
		end else if (unit_control_write && unit_control_register == UM_OFF) begin
			cmp_out_r <= 1'b0;
		end else if (cmp_event) begin
			case (unit_control_register)
				UM_CMP_SET:    cmp_out_r <= 1'b1;
				UM_CMP_CLR:    cmp_out_r <= 1'b0;
				UM_CMP_TOGGLE: cmp_out_r <= ~cmp_out_r;
				default:       cmp_out_r <= cmp_out_r;
			endcase
		end
	end

	// ==========================================================
	// interrupt flag, conversion trigger, wake
	logic flag_r;
	logic conv_r;
	logic flag_event;

	// qualifying event per mode: compare match or pwm period start
	assign flag_event = cmp_event || (pwm_mode && pulse_start);

	// set wins over a clear in the same cycle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			flag_r <= 1'b0;
		end else if (flag_event) begin
			flag_r <= 1'b1;
		end else if (flag_clear) begin
			flag_r <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			conv_r <= 1'b0;
		end else begin
			conv_r <= conv_src_sel && cmp_event;
		end
	end

	assign unit_interrupt_flag = flag_r;
	assign conv_trigger        = conv_r;
	// in sleep only a running timebase produces matches
	assign wake_request        = sleep_mode && flag_r && cmp_tb_run;

	// ==========================================================
	// output mux; pin direction and routing live outside
	logic unit_out_r;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			unit_out_r <= 1'b0;
		end else begin
			unit_out_r <= pwm_mode ? pwm_r : cmp_out_r;
		end
	end

	assign compare_pwm_pin   = unit_out_r;
	assign unit_out_internal = unit_out_r;
endmodule

// >>> verif/pwm_load.sv
// pwm_load: external load on the unit pin, measuring each high pulse
// assumes: pin sampled on mclk, driven low under reset
`timescale 1ns/1ps
module pwm_load (
	input  wire logic mclk,
	input  wire logic drive,
	output int        hi_len,
	output int        pulses
);
	// ==========================================================
	// pulse measurement
	int run = 0;
	int hl  = 0;
	int np  = 0;
	assign hi_len = hl;
	assign pulses = np;
	// load samples the pin on every rising mclk edge; there is no output enable here
	always @(posedge mclk) begin
		if (drive === 1'b1) begin
			run++;
		end else if (run > 0) begin
			hl = run;
			np++;
			run = 0;
		end
	end
endmodule

// >>> verif/compare_pwm_one_shot_checker.sv
// compare_pwm_one_shot_checker: port-level assertions for the unit
// assumes: bound to compare_pwm_one_shot, single clock mclk
`timescale 1ns/1ps
module compare_pwm_one_shot_checker
	import cmp_pwm_pkg::*;
(
	input wire logic               mclk,
	input wire logic               rst_n,
	input wire logic               tb_enable_clr,
	input wire logic               trig_pin,
	input wire logic               unit_control_write,
	input wire logic               conv_src_sel,
	input wire logic               sleep_mode,
	input wire logic               cmp_tb_run,
	input wire logic               flag_clear,
	input wire logic               tb_enable,
	input wire logic               unit_interrupt_flag,
	input wire logic               conv_trigger,
	input wire logic               wake_request,
	input wire logic               compare_pwm_pin,
	input wire logic               unit_out_internal,
	input wire logic [MODE_W-1:0]  tb_mode,
	input wire logic [TB_W-1:0]    pwm_timebase_period,
	input wire logic [TB_W-1:0]    tb_count,
	input wire logic [UMODE_W-1:0] unit_control_register,
	input wire logic [DUTY_W-1:0]  pwm_duty
);
	// ==========================================================
	// helpers and sequences
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic one_shot;
	assign one_shot = (tb_mode == TB_MODE_LVL_LOW) || (tb_mode == TB_MODE_LVL_HIGH);
	// pin held low long enough for the synchroniser, then a clean rise
	sequence s_armed_start;
		(tb_enable && tb_mode == TB_MODE_LVL_LOW && unit_control_register == UM_PWM
		&& pwm_duty >= 10'h010 && pwm_timebase_period != 8'h00 && !trig_pin) [*3]
		##1 $rose(trig_pin) ##1 trig_pin [*3];
	endsequence
	sequence s_shot_done;
		$fell(tb_enable) && one_shot && !$past(tb_enable_clr);
	endsequence
	// ==========================================================
	// assertions
	a_level_hold_zero: assert property ((one_shot && trig_pin == tb_mode[0]) [*6] |-> tb_count == TB_RST)
		else $error("count moved at reset level");
	a_match_clears_en: assert property (s_shot_done |-> tb_count == TB_RST)
		else $error("count not cleared at period match");
	a_idle_no_count: assert property (!tb_enable && one_shot |=> tb_count <= $past(tb_count))
		else $error("count advanced while disabled");
	a_pulse_on_start: assert property (s_armed_start |=> compare_pwm_pin)
		else $error("pin not active after start edge");
	a_single_pulse: assert property ((s_shot_done and unit_control_register == UM_PWM)
		|-> ##2 !compare_pwm_pin [*4])
		else $error("pin active after one-shot end");
	a_zero_duty_off: assert property ((unit_control_register == UM_PWM && pwm_duty == 10'h000) [*4] |-> !compare_pwm_pin)
		else $error("pin high at zero duty");
	a_ctrl_zero_low: assert property (unit_control_write && unit_control_register == UM_OFF |-> ##[1:2] !compare_pwm_pin)
		else $error("latch not forced low");
	a_out_mirror: assert property (unit_out_internal == compare_pwm_pin)
		else $error("internal copy differs from pin");
	a_flag_sticky: assert property (unit_interrupt_flag && !flag_clear |=> unit_interrupt_flag)
		else $error("flag dropped without clear");
	a_conv_pulse: assert property (conv_trigger |-> unit_interrupt_flag && $past(conv_src_sel) ##1 !conv_trigger)
		else $error("bad conversion trigger");
	a_wake_sleep: assert property (wake_request == (sleep_mode && unit_interrupt_flag && cmp_tb_run))
		else $error("wake request mismatch");
endmodule
bind compare_pwm_one_shot compare_pwm_one_shot_checker chk_i (
	.mclk                 (mclk),
	.rst_n                (rst_n),
	.tb_enable_clr        (tb_enable_clr),
	.trig_pin             (trig_pin),
	.unit_control_write   (unit_control_write),
	.conv_src_sel         (conv_src_sel),
	.sleep_mode           (sleep_mode),
	.cmp_tb_run           (cmp_tb_run),
	.flag_clear           (flag_clear),
	.tb_enable            (tb_enable),
	.unit_interrupt_flag  (unit_interrupt_flag),
	.conv_trigger         (conv_trigger),
	.wake_request         (wake_request),
	.compare_pwm_pin      (compare_pwm_pin),
	.unit_out_internal    (unit_out_internal),
	.tb_mode              (tb_mode),
	.pwm_timebase_period  (pwm_timebase_period),
	.tb_count             (tb_count),
	.unit_control_register(unit_control_register),
	.pwm_duty             (pwm_duty)
);

// >>> verif/test_compare_pwm_one_shot.sv
// test_compare_pwm_one_shot: self-checking bench for the compare/pwm unit
// assumes: checker bound to the design, load model on the pin
`timescale 1ns/1ps
module test_compare_pwm_one_shot;
	import cmp_pwm_pkg::*;
	// ==========================================================
	// stimulus and observed signals
	logic mclk = 0, rst_n = 0, tb_enable_set = 0, tb_enable_clr = 0, trig_pin = 0;
	logic unit_control_write = 0, cmp_clk_ext_sel = 0, cmp_ext_clk = 0, cmp_tb_run = 0;
	logic sleep_mode = 0, conv_src_sel = 0, flag_clear = 0;
	logic [MODE_W-1:0]  tb_mode = TB_MODE_FREE;
	logic [TB_W-1:0]    pwm_timebase_period = 8'h04;
	logic [UMODE_W-1:0] unit_control_register = UM_OFF;
	logic [DUTY_W-1:0]  pwm_duty = 10'h000;
	logic [7:0]         compare_value_high = 8'h00, compare_value_low = 8'h20;
	logic tb_enable, unit_interrupt_flag, conv_trigger, wake_request, compare_pwm_pin;
	logic unit_out_internal;
	logic [TB_W-1:0]    tb_count;
	logic [CMP_W-1:0]   cmp_value;
	int hi_len, pulses, err_count = 0, cmp_count = 0;
	logic [UMODE_W-1:0] cm [4] = '{UM_CMP_SET, UM_CMP_CLR, UM_CMP_TOGGLE, UM_CMP_TRIG};

	compare_pwm_one_shot dut (.*, .cmp_count(cmp_value));
	pwm_load load (.mclk(mclk), .drive(compare_pwm_pin), .hi_len(hi_len), .pulses(pulses));

	always #12.5 mclk = ~mclk;
	// ==========================================================
	// helpers: inputs always move 2 ns after the rising edge
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask
	task automatic final_report;
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// pulse start follows the free-running prescale phase, so allow one tick
	task automatic chk_near(input int got, input int exp, input string what);
		cmp_count++;
		if (got < exp - 4 || got > exp + 4) begin
			err_count++;
			$display("[FAIL] %0t %s got %0d exp %0d", $time, what, got, exp);
		end
	endtask
	function automatic logic seen(input int w);
		case (w)
			0: return tb_enable === 1'b0;
			1: return unit_interrupt_flag === 1'b1;
			default: return conv_trigger === 1'b1;
		endcase
	endfunction
	task automatic wait_on(input int w);
		int i;
		for (i = 0; i < 3000 && !seen(w); i++) cyc(1);
		if (i >= 3000) begin
			err_count++;
			$display("[FAIL] %0t wait timed out", $time);
			final_report();
		end
	endtask
	task automatic do_reset;
		rst_n = 0;
		cyc(12);
		rst_n = 1;
		cyc(1);
	endtask
	task automatic pulse_en;
		tb_enable_set = 1;
		cyc(1);
		tb_enable_set = 0;
	endtask
	// ==========================================================
	// main sequence
	initial begin
		int per, duty, base;
		logic lvl;
		logic [15:0] cv;
		void'($urandom(32'he413));
		do_reset();
		// one-shot in both reset levels
		for (int m = 0; m < 2; m++) begin
			lvl = m[0];
			tb_mode = m ? TB_MODE_LVL_HIGH : TB_MODE_LVL_LOW;
			trig_pin = lvl;
			per = 5 + $urandom_range(7);
			duty = $urandom_range(4 * per - 4, 16);
			pwm_timebase_period = 8'(per);
			pwm_duty = 10'(duty);
			unit_control_register = UM_PWM;
			unit_control_write = 1;
			cyc(1);
			unit_control_write = 0;
			pulse_en();
			cyc(20);
			chk(tb_count, 16'h0, "held count");
			base = pulses;
			trig_pin = !lvl;
			wait_on(0);
			chk(tb_count, 16'h0, "count after shot");
			cyc(4);
			chk_near(hi_len, duty, "one-shot width");
			chk(16'(pulses - base), 16'h1, "pulses per edge");
			pulse_en();
			cyc(60);
			chk(16'(pulses - base), 16'h1, "restart without edge");
			trig_pin = lvl;
			cyc(8);
			trig_pin = !lvl;
			wait_on(0);
			cyc(4);
			chk(16'(pulses - base), 16'h2, "fresh edge restarts");
			// software clear right after set: a later edge must not start a shot
			pulse_en();
			tb_enable_clr = 1;
			cyc(1);
			tb_enable_clr = 0;
			trig_pin = lvl;
			cyc(8);
			trig_pin = !lvl;
			cyc(60);
			chk(tb_enable, 16'h0, "enable cleared");
			chk(16'(pulses - base), 16'h2, "no start after clear");
			$display("one-shot level %0d done", m);
		end
		// free-running pwm: zero, middle and full duty
		tb_mode = TB_MODE_FREE;
		pwm_timebase_period = 8'h09;
		pulse_en();
		for (int d = 0; d < 3; d++) begin
			pwm_duty = (d == 0) ? 10'h000 : (d == 1) ? 10'(16 + $urandom_range(15)) : 10'h3ff;
			// a pulse under the old duty may still end: wait out one period
			cyc(48);
			base = pulses;
			cyc(200);
			if (d == 1) begin
				chk_near(hi_len, int'(pwm_duty), "pwm width");
				chk(16'(pulses - base >= 4), 16'h1, "pwm repeats");
			end else begin
				chk(compare_pwm_pin, 16'(d == 2), "steady level");
				chk(16'(pulses - base), 16'h0, "no edges");
			end
		end
		chk(unit_interrupt_flag, 16'h1, "pwm flag");
		$display("standard pwm done");
		// compare modes, each from a fresh reset
		foreach (cm[i]) begin
			do_reset();
			unit_control_register = cm[i];
			unit_control_write = 1;
			conv_src_sel = 1;
			sleep_mode = i[0];
			cv = 16'(8 + $urandom_range(40));
			{compare_value_high, compare_value_low} = cv;
			cyc(1);
			unit_control_write = 0;
			cmp_tb_run = 1;
			wait_on(cm[i] == UM_CMP_TRIG ? 2 : 1);
			chk(unit_interrupt_flag, 16'h1, "compare flag");
			chk(conv_trigger, 16'h1, "conversion trigger");
			chk(cmp_value, cv, "count at match");
			chk(wake_request, 16'(sleep_mode), "wake");
			cyc(2);
			chk(cmp_value, (cm[i] == UM_CMP_TRIG) ? 16'h0 : cv, "count after");
			chk(compare_pwm_pin, 16'(cm[i] inside {UM_CMP_SET, UM_CMP_TOGGLE}), "latch");
			if (cm[i] == UM_CMP_SET) begin
				unit_control_register = UM_OFF;
				unit_control_write = 1;
				cyc(1);
				unit_control_write = 0;
				cyc(2);
				chk(compare_pwm_pin, 16'h0, "latch forced low");
			end
			flag_clear = 1;
			cyc(1);
			flag_clear = 0;
			chk(unit_interrupt_flag, 16'h0, "flag cleared");
			cmp_tb_run = 0;
			$display("compare mode %h done", cm[i]);
		end
		final_report();
	end
endmodule
